// file: common/sras_link_if.sv
`timescale 1ns/10ps
`default_nettype none

interface sras_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;

    // ------------------------------------------------------------
    // Shared return line, pulled up when nobody drives it
    // ------------------------------------------------------------
    assign miso = miso_oe ? miso_o : sras_pkg::MISO_IDLE;

    modport dev (
        input sclk,
        input cs_n,
        input mosi,
        output miso_o,
        output miso_oe
    );

    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input miso
    );
endinterface : sras_link_if

`default_nettype wire

// file: common/sras_pkg.sv
package sras_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int WORD_W = 16;
    localparam int HDR_BITS = 8;
    localparam int CNT_W = 5;
    localparam int IDX_W = 8;
    localparam logic DIR_WRITE = 1'b1;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Addresses that do not advance in a burst
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_HOLD_LO = 7'h5f;
    localparam logic [ADDR_W-1:0] ADDR_FIFO = 7'h60;
    localparam logic [ADDR_W-1:0] ADDR_HOLD_HI = 7'h7f;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCLK_MAX_MHZ = 10;
    localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
    localparam int SCLK_HALF_MIN_CYC = (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    // Margin for the two-stage input sync on the return line
    localparam int HOST_HALF_CYC = 2 * SCLK_HALF_MIN_CYC;
    localparam logic MISO_IDLE = 1'b1;

    typedef enum {
        SRAS_IDLE,
        SRAS_LEAD,
        SRAS_LOW,
        SRAS_HIGH,
        SRAS_SAMP,
        SRAS_NEXT,
        SRAS_END
    } sras_hstate_t;

endpackage : sras_pkg

// file: rtl/sras_dev.sv
`timescale 1ns/10ps
`default_nettype none

module sras_dev (
    // Link
    sras_link_if.dev link,
    // Housekeeping
    input wire logic reset,
    // Register side
    output logic [sras_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sras_pkg::WORD_W-1:0] rd_data,
    output logic rd_frame,
    // Completed word events
    output logic [sras_pkg::ADDR_W-1:0] ev_addr,
    output logic [sras_pkg::IDX_W-1:0] ev_index,
    output logic [sras_pkg::WORD_W-1:0] wr_data,
    output logic wr_toggle,
    output logic rd_toggle
);
    import sras_pkg::*;

    // ------------------------------------------------------------
    // Frame state, all on the link clock
    // ------------------------------------------------------------
    logic [CNT_W-1:0] bit_cnt;
    logic in_hdr;
    logic [WORD_W-1:0] shift_in;
    logic is_write;
    logic is_read;
    logic [IDX_W-1:0] word_idx;
    logic [WORD_W-1:0] shift_out;
    logic drive;
    logic hdr_done;
    logic word_done;
    logic [WORD_W-1:0] word_in;

    function automatic logic addr_held(input logic [ADDR_W-1:0] a);
        return (a == ADDR_HOLD_LO) || (a == ADDR_FIFO) || (a == ADDR_HOLD_HI);
    endfunction : addr_held

    assign hdr_done = in_hdr && (bit_cnt == CNT_W'(HDR_BITS - 1));
    assign word_done = !in_hdr && (bit_cnt == CNT_W'(WORD_W - 1));
    assign word_in = {shift_in[WORD_W-2:0], link.mosi};

    // ------------------------------------------------------------
    // Bit counter
    // ------------------------------------------------------------
    // The clock stops between frames, so the frame signal itself
    // must clear the counters; no edge comes after the last bit.
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            bit_cnt <= '0;
            in_hdr <= 1'b1;
        end else if (hdr_done) begin
            bit_cnt <= '0;
            in_hdr <= 1'b0;
        end else if (word_done) begin
            bit_cnt <= '0;
        end else begin
            bit_cnt <= bit_cnt + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Input shifter
    // ------------------------------------------------------------
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            shift_in <= WORD_RESET;
        end else begin
            shift_in <= word_in;
        end
    end

    // ------------------------------------------------------------
    // Header decode and address walk
    // ------------------------------------------------------------
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            reg_addr <= ADDR_RESET;
            is_write <= 1'b0;
            is_read <= 1'b0;
        end else if (hdr_done) begin
            reg_addr <= shift_in[ADDR_W-1:0];
            is_write <= (link.mosi == DIR_WRITE);
            is_read <= (link.mosi != DIR_WRITE);
        end else if (word_done && !addr_held(reg_addr)) begin
            reg_addr <= reg_addr + ADDR_W'(1);
        end
    end

    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            word_idx <= '0;
        end else if (word_done) begin
            word_idx <= word_idx + IDX_W'(1);
        end
    end

    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            rd_frame <= 1'b0;
        end else if (hdr_done) begin
            rd_frame <= (link.mosi != DIR_WRITE);
        end
    end

    // ------------------------------------------------------------
    // Word events
    // ------------------------------------------------------------
    // Toggles, not pulses: the clock may stop right after the last
    // bit, so a pulse could never be seen to end. Chip select does
    // not reset them, else a frame end would look like an event.
    always_ff @(posedge link.sclk or posedge reset) begin
        if (reset) begin
            ev_addr <= ADDR_RESET;
            ev_index <= '0;
        end else if (word_done && (is_write || is_read)) begin
            ev_addr <= reg_addr;
            ev_index <= word_idx;
        end
    end

    always_ff @(posedge link.sclk or posedge reset) begin
        if (reset) begin
            wr_data <= WORD_RESET;
            wr_toggle <= 1'b0;
        end else if (word_done && is_write) begin
            wr_data <= word_in;
            wr_toggle <= ~wr_toggle;
        end
    end

    always_ff @(posedge link.sclk or posedge reset) begin
        if (reset) begin
            rd_toggle <= 1'b0;
        end else if (word_done && is_read) begin
            rd_toggle <= ~rd_toggle;
        end
    end

    // ------------------------------------------------------------
    // Return path, falling edges
    // ------------------------------------------------------------
    // A word is loaded on the fall after a word boundary; rd_data
    // must follow reg_addr within half a link clock period.
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            shift_out <= WORD_RESET;
        end else if (is_read && bit_cnt == '0) begin
            shift_out <= rd_data;
        end else begin
            shift_out <= {shift_out[WORD_W-2:0], 1'b0};
        end
    end

    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            drive <= 1'b0;
        end else if (is_read) begin
            drive <= 1'b1;
        end
    end

    // Clock is only ever an input here
    assign link.miso_o = shift_out[WORD_W-1];
    assign link.miso_oe = drive;

endmodule : sras_dev

`default_nettype wire

// file: rtl/sras_host.sv
`timescale 1ns/10ps
`default_nettype none

module sras_host #(
    parameter int HALF_CYC = sras_pkg::HOST_HALF_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link
    sras_link_if.host link,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [sras_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [sras_pkg::IDX_W-1:0] cmd_words,
    // Write words
    input wire logic [sras_pkg::WORD_W-1:0] wr_data,
    output logic wr_take,
    // Read words
    output logic [sras_pkg::WORD_W-1:0] rd_data,
    output logic rd_valid,
    output logic done
);
    import sras_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sras_hstate_t state;
    logic [15:0] half_cnt;
    logic tick;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_m;
    logic miso_s;
    logic [WORD_W-1:0] tx;
    logic [WORD_W-1:0] rx;
    logic [CNT_W-1:0] bits;
    logic [IDX_W-1:0] words;
    logic hdr;
    logic is_wr;

    assign tick = (half_cnt == 16'(HALF_CYC - 1));
    assign link.sclk = sclk;
    assign link.cs_n = cs_n;
    assign link.mosi = mosi;

    // ------------------------------------------------------------
    // Return line sync
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            miso_m <= MISO_IDLE;
            miso_s <= MISO_IDLE;
        end else begin
            miso_m <= link.miso;
            miso_s <= miso_m;
        end
    end

    // Divider; HALF_CYC keeps the clock at or under the link limit
    always_ff @(posedge clk) begin
        if (reset || tick || state == SRAS_IDLE || state == SRAS_NEXT) begin
            half_cnt <= '0;
        end else begin
            half_cnt <= half_cnt + 16'(1);
        end
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        wr_take <= 1'b0;
        rd_valid <= 1'b0;
        done <= 1'b0;
        if (reset) begin
            state <= SRAS_IDLE;
            cmd_ready <= 1'b0;
            sclk <= 1'b1;
            cs_n <= 1'b1;
            mosi <= 1'b1;
            tx <= WORD_RESET;
            rx <= WORD_RESET;
            rd_data <= WORD_RESET;
            bits <= '0;
            words <= '0;
            hdr <= 1'b0;
            is_wr <= 1'b0;
        end else begin
            case (state)
                SRAS_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        cs_n <= 1'b0;
                        tx <= {cmd_addr, cmd_write, 8'h00};
                        bits <= CNT_W'(HDR_BITS);
                        words <= cmd_words;
                        hdr <= 1'b1;
                        is_wr <= cmd_write;
                        state <= SRAS_LEAD;
                    end
                end
                SRAS_LEAD: begin
                    if (tick) begin
                        state <= SRAS_LOW;
                    end
                end
                SRAS_LOW: begin
                    if (tick) begin
                        sclk <= 1'b0;
                        mosi <= tx[WORD_W-1];
                        tx <= {tx[WORD_W-2:0], 1'b0};
                        state <= SRAS_HIGH;
                    end
                end
                SRAS_HIGH: begin
                    if (tick) begin
                        sclk <= 1'b1;
                        bits <= bits - CNT_W'(1);
                        state <= SRAS_SAMP;
                    end
                end
                SRAS_SAMP: begin
                    // Sample halfway through the high phase to cover the sync delay
                    if (tick) begin
                        rx <= {rx[WORD_W-2:0], miso_s};
                        state <= (bits == '0) ? SRAS_NEXT : SRAS_LOW;
                    end
                end
                SRAS_NEXT: begin
                    if (!hdr && !is_wr) begin
                        rd_data <= rx;
                        rd_valid <= 1'b1;
                    end
                    if (!hdr) begin
                        words <= words - IDX_W'(1);
                    end
                    hdr <= 1'b0;
                    if ((hdr && words == '0) || (!hdr && words == IDX_W'(1))) begin
                        state <= SRAS_END;
                    end else begin
                        bits <= CNT_W'(WORD_W);
                        tx <= is_wr ? wr_data : WORD_RESET;
                        wr_take <= is_wr;
                        state <= SRAS_LOW;
                    end
                end
                SRAS_END: begin
                    if (tick) begin
                        cs_n <= 1'b1;
                        mosi <= 1'b1;
                        done <= 1'b1;
                        state <= SRAS_IDLE;
                    end
                end
                default: begin
                    state <= SRAS_IDLE;
                end
            endcase
        end
    end

endmodule : sras_host

`default_nettype wire

// file: tb/sras_checker.sv
`timescale 1ns/10ps
`default_nettype none

module sras_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic miso
);
    import sras_pkg::*;

    // ------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------
    logic [7:0] edges;
    logic dir;
    logic [7:0] frame_len;

    // Saturates, so very long bursts are not judged
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) edges <= 8'h00;
        else if (edges != 8'hff) edges <= edges + 8'h01;
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) dir <= DIR_WRITE;
        else if (edges == 8'h07) dir <= mosi;
    end

    // Held in the fast domain: the link count clears the moment the frame closes
    always_ff @(posedge clk) begin
        if (reset) frame_len <= 8'h08;
        else if (!cs_n) frame_len <= edges;
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence hdr_done_s;
        edges >= 8'h08;
    endsequence

    sequence read_frame_s;
        hdr_done_s ##0 !dir;
    endsequence

    idle_clock_high_a: assert property (cs_n |-> sclk)
        else $error("serial clock low outside a frame");
    lead_clock_high_a: assert property ($fell(cs_n) |-> sclk ##1 sclk)
        else $error("serial clock fell with chip select");
    sclk_rate_a: assert property ($changed(sclk) |=> $stable(sclk))
        else $error("serial clock phase too short");
    line_released_a: assert property (cs_n |-> !miso_oe && miso == MISO_IDLE)
        else $error("return line driven outside a frame");
    no_early_drive_a: assert property (!cs_n && edges < 8'h08 |-> !miso_oe)
        else $error("return line driven during header");
    write_no_drive_a: assert property (hdr_done_s ##0 dir |-> !miso_oe)
        else $error("return line driven in a write frame");
    read_drive_a: assert property (@(posedge sclk) disable iff (cs_n) read_frame_s |-> miso_oe)
        else $error("return line not driven in a read frame");
    fall_launch_a: assert property (miso_oe && $changed(miso_o) |-> !sclk)
        else $error("return bit changed while clock high");
    word_frames_a: assert property ($rose(cs_n) && frame_len != 8'hff |-> frame_len[3:0] == 4'h8)
        else $error("frame closed on a partial word");

    read_cov_c: cover property (read_frame_s);

endmodule : sras_checker

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, want) begin checked++; if ((got) !== (want)) begin errors++; \
    $display("mismatch at %0t: got %h want %h", $time, (got), (want)); end end

module tb_top;
    import sras_pkg::*;

    typedef struct packed {
        logic w;
        logic [ADDR_W-1:0] a;
        logic [IDX_W-1:0] n;
    } sras_row_t;

    // ------------------------------------------------------------
    // Cases: write, read back, held addresses, buffer port, header only
    // ------------------------------------------------------------
    localparam int ROWS = 7;
    sras_row_t rows [ROWS] = '{'{1'b1, 7'h10, 8'h02}, '{1'b0, 7'h10, 8'h02}, '{1'b1, 7'h5e, 8'h03},
        '{1'b0, 7'h5e, 8'h03}, '{1'b0, 7'h7e, 8'h03}, '{1'b0, 7'h60, 8'h03}, '{1'b1, 7'h7f, 8'h00}};

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, wr_take, rd_valid, done, wr_toggle, rd_toggle;
    logic wr_toggle_b, t0, rd_frame;
    logic [ADDR_W-1:0] cmd_addr = 7'h00, reg_addr, ev_addr, reg_addr_b, ev_addr_b;
    logic [IDX_W-1:0] cmd_words = 8'h00, ev_index;
    logic [WORD_W-1:0] h_wr_data, h_rd_data, d_rd_data, d_wr_data, wr_data_b, q;
    logic [WORD_W-1:0] regs [128], want [128], fifo [8], wbuf [4];
    logic [30:0] evq [$];
    logic [WORD_W-1:0] rdq [$];
    logic [ADDR_W-1:0] rdaq [$];
    int errors = 0, checked = 0, widx = 0, fptr = 0, fexp = 0;

    sras_link_if link ();
    sras_link_if link_b ();

    sras_host #(.HALF_CYC(4)) sras_host_inst (.clk(clk), .reset(reset), .link(link.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_words(cmd_words), .wr_data(h_wr_data),
        .wr_take(wr_take), .rd_data(h_rd_data), .rd_valid(rd_valid), .done(done));
    sras_dev sras_dev_inst (.link(link.dev), .reset(reset), .reg_addr(reg_addr), .rd_data(d_rd_data), .rd_frame(rd_frame),
        .ev_addr(ev_addr), .ev_index(ev_index), .wr_data(d_wr_data), .wr_toggle(wr_toggle), .rd_toggle(rd_toggle));
    // Second device faces the bench's own driver, which can break a frame off
    sras_dev sras_dev_b_inst (.link(link_b.dev), .reset(reset), .reg_addr(reg_addr_b), .rd_data(16'hc3a5), .rd_frame(),
        .ev_addr(ev_addr_b), .ev_index(), .wr_data(wr_data_b), .wr_toggle(wr_toggle_b), .rd_toggle());
    sras_checker sras_checker_inst (.clk(clk), .reset(reset), .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
        .miso_o(link.miso_o), .miso_oe(link.miso_oe), .miso(link.miso));

    assign d_rd_data = (reg_addr == ADDR_FIFO) ? fifo[fptr] : regs[reg_addr];
    assign h_wr_data = wbuf[widx];

    initial begin
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (wr_take) widx <= widx + 1;
        if (rd_valid) rdq.push_back(h_rd_data);
    end

    // Short delay lets the event fields land with their toggle
    always @(wr_toggle) begin
        #1;
        if (!reset) begin
            evq.push_back({ev_addr, ev_index, d_wr_data});
            `CHK(rd_frame, 1'b0)
            regs[ev_addr] = d_wr_data;
        end
    end

    always @(rd_toggle) begin
        #1;
        if (!reset) begin
            rdaq.push_back(ev_addr);
            `CHK(rd_frame, 1'b1)
            if (ev_addr == ADDR_FIFO) fptr++;
        end
    end

    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
        return (a == ADDR_HOLD_LO || a == ADDR_FIFO || a == ADDR_HOLD_HI) ? a : a + 7'h01;
    endfunction : next_addr

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run

    task automatic run_row(input sras_row_t r, input int id);
        int k;
        logic [ADDR_W-1:0] ea;
        logic [WORD_W-1:0] exp_w;
        evq.delete();
        rdq.delete();
        rdaq.delete();
        widx = 0;
        ea = r.a;
        for (k = 0; k < 4; k++) wbuf[k] = {1'b1, r.a, 8'h5a ^ 8'(k)};
        for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(posedge clk) #2;
        cmd_write = r.w;
        cmd_addr = r.a;
        cmd_words = r.n;
        cmd_valid = 1'b1;
        @(posedge clk) #2;
        cmd_valid = 1'b0;
        for (k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clk) #2;
        `CHK(done, 1'b1)
        `CHK(evq.size(), r.w ? int'(r.n) : 0)
        `CHK(rdq.size(), r.w ? 0 : int'(r.n))
        for (k = 0; k < int'(r.n); k++) begin
            exp_w = (ea == ADDR_FIFO) ? fifo[fexp] : want[ea];
            if (r.w) begin
                want[ea] = wbuf[k];
                `CHK(evq[k], {ea, 8'(k), wbuf[k]})
            end else begin
                `CHK(rdq[k], exp_w)
                `CHK(rdaq[k], ea)
            end
            if (!r.w && ea == ADDR_FIFO) fexp++;
            ea = next_addr(ea);
        end
        $display("test %0d done", id);
    endtask : run_row

    // Bench-made link clock, stopped between frames
    task automatic b_bits(input logic [WORD_W-1:0] v, input int n);
        int i;
        for (i = 15; i > 15 - n; i--) begin
            link_b.sclk = 1'b0;
            link_b.mosi = v[i];
            #32;
            q = {q[14:0], link_b.miso};
            link_b.sclk = 1'b1;
            #32;
        end
    endtask : b_bits

    task automatic b_frame(input logic [7:0] hdr, input logic [WORD_W-1:0] v, input int n);
        link_b.cs_n = 1'b0;
        #32;
        b_bits({hdr, 8'h00}, 8);
        b_bits(v, n);
        link_b.cs_n = 1'b1;
        #64;
    endtask : b_frame

    initial begin
        link_b.cs_n = 1'b1;
        link_b.sclk = 1'b1;
        link_b.mosi = 1'b1;
        q = 16'h0000;
        for (int i = 0; i < 128; i++) begin
            regs[i] = {~8'(i), 8'(i)};
            want[i] = regs[i];
        end
        for (int i = 0; i < 8; i++) fifo[i] = {8'hf0 | 8'(i), 8'(i * 3)};
        repeat (4) @(posedge clk);
        #2 reset = 1'b0;
        for (int r = 0; r < ROWS; r++) run_row(rows[r], r);
        // Frame cut off after ten data bits, then a whole one
        t0 = wr_toggle_b;
        b_frame({7'h20, 1'b1}, 16'h5a3c, 10);
        `CHK(wr_toggle_b, t0)
        `CHK(reg_addr_b, ADDR_RESET)
        b_frame({7'h20, 1'b1}, 16'h5a3c, 16);
        `CHK(wr_toggle_b, ~t0)
        `CHK(wr_data_b, 16'h5a3c)
        `CHK(ev_addr_b, 7'h20)
        `CHK(q, 16'hffff)
        b_frame({7'h21, 1'b0}, 16'hffff, 16);
        `CHK(q, 16'hc3a5)
        `CHK(link_b.miso, MISO_IDLE)
        $display("test link abort done");
        @(posedge clk) #2;
        reset = 1'b1;
        repeat (4) @(posedge clk) #2;
        `CHK(cmd_ready, 1'b0)
        `CHK(ev_addr, ADDR_RESET)
        `CHK(link.cs_n, 1'b1)
        `CHK(link.sclk, 1'b1)
        reset = 1'b0;
        run_row(rows[1], 7);
        complete_run();
    end

    initial begin
        #400000;
        errors++;
        $display("mismatch at %0t: run did not finish", $time);
        complete_run();
    end

endmodule : tb_top

`default_nettype wire
